// [cssis_cfg.svh]
`ifndef CSSIS_CFG_SVH
`define CSSIS_CFG_SVH

// ************************************************************
// start-up step lengths, counted in clock cycles of each source
// ************************************************************
`define CSSIS_CNT_W 18
`define CSSIS_REF_CYCLES 18'h10000
`define CSSIS_CAL_CYCLES 18'h20000
`define CSSIS_LOCK_CYCLES 18'h00901
`define CSSIS_CW_DEFAULT 32
`define CSSIS_FB_PER_CW 2048

// ************************************************************
// pin synchroniser bit positions
// ************************************************************
`define CSSIS_SYNC_W 8
`define CSSIS_B_PDN 0
`define CSSIS_B_RSTN 1
`define CSSIS_B_MODE 2
`define CSSIS_B_CHOICE 3
`define CSSIS_B_XTAL 4
`define CSSIS_B_PRI 5
`define CSSIS_B_SEC 6
`define CSSIS_B_FB 7

// ************************************************************
// reference activity timeout, in system clock cycles
// ************************************************************
`define CSSIS_ACT_W 12
`define CSSIS_ACT_TIMEOUT 4000

`endif

// [cssis_pkg.sv]
package cssis_pkg;

  // ************************************************************
  // start-up sequencer states
  // ************************************************************
  typedef enum logic [2:0]
  {
    ST_RESET = 3'b000,
    ST_REF_CNT = 3'b001,
    ST_FB_CNT = 3'b010,
    ST_CAL = 3'b011,
    ST_ON = 3'b100,
    ST_LOCKED = 3'b101
  } cssis_state_t;

endpackage

// [cssis_cnt.sv]
`timescale 1ns/10ps
`include "cssis_cfg.svh"

// ************************************************************
// step counter shared by all start-up steps
// ************************************************************
module cssis_cnt
#(
  parameter int WIDTH = `CSSIS_CNT_W
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic inc,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // clear has priority so a new step always starts from zero
  always_comb
  begin
    count_nxt = count_r;
    if (clr)
      count_nxt = '0;
    else if (inc)
      count_nxt = count_r + 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  assign count = count_r;

endmodule

// [cssis_top.sv]
`timescale 1ns/10ps
`include "cssis_cfg.svh"

module cssis_top
  import cssis_pkg::*;
#(
  parameter int COUNTER_WIDTH_SETTING = `CSSIS_CW_DEFAULT,
  parameter int ACT_TIMEOUT = `CSSIS_ACT_TIMEOUT,
  parameter int REF_CYCLES = `CSSIS_REF_CYCLES,
  parameter int CAL_CYCLES = `CSSIS_CAL_CYCLES
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic POWER_DOWN_N,
  input wire logic ACTIVE_LOW_RESET_PIN_N,
  input wire logic INTERFACE_MODE_PIN,
  input wire logic INPUT_CHOICE_PIN,
  input wire logic XTAL_AMP_OK,
  input wire logic PRIMARY_REFERENCE_INPUT,
  input wire logic SECONDARY_REFERENCE_INPUT,
  input wire logic FEEDBACK_CLOCK,
  input wire logic MUX_MANUAL_SELECT_BIT,
  input wire logic MUX_REGISTER_CHOICE_BIT,
  input wire logic PIN_MODE_AUTO,
  input wire logic REG_RESET_BIT,
  input wire logic XTAL_USED,
  input wire logic LOCK_ON_A,
  input wire logic LOCK_ON_B,
  output logic MUX_OUTPUT,
  output logic SELECT_SECONDARY,
  output logic DEVICE_IN_RESET,
  output logic LOAD_DEFAULTS,
  output logic CAL_KEEP_PLAN,
  output logic VCO_CAL_ACTIVE,
  output logic OUTPUT_ENABLE,
  output logic OUTPUT_HOLD_RESET,
  output logic INDICATOR_PIN_A,
  output logic INDICATOR_PIN_B
);

  localparam logic [`CSSIS_CNT_W-1:0] FB_CYCLES =
    `CSSIS_CNT_W'(COUNTER_WIDTH_SETTING * `CSSIS_FB_PER_CW);
  localparam logic [`CSSIS_ACT_W-1:0] ACT_LIMIT = `CSSIS_ACT_W'(ACT_TIMEOUT);
  // last count value of the reference and calibration steps, cut to the step counter's width
  localparam logic [`CSSIS_CNT_W-1:0] REF_LAST = `CSSIS_CNT_W'(REF_CYCLES - 1);
  localparam logic [`CSSIS_CNT_W-1:0] CAL_LAST = `CSSIS_CNT_W'(CAL_CYCLES - 1);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`CSSIS_SYNC_W-1:0] pins;
  logic [`CSSIS_SYNC_W-1:0] meta_r;
  logic [`CSSIS_SYNC_W-1:0] meta_nxt;
  logic [`CSSIS_SYNC_W-1:0] sync_r;
  logic [`CSSIS_SYNC_W-1:0] sync_nxt;
  logic [`CSSIS_SYNC_W-1:0] old_r;
  logic [`CSSIS_SYNC_W-1:0] old_nxt;

  assign pins = {FEEDBACK_CLOCK, SECONDARY_REFERENCE_INPUT, PRIMARY_REFERENCE_INPUT,
                 XTAL_AMP_OK, INPUT_CHOICE_PIN, INTERFACE_MODE_PIN,
                 ACTIVE_LOW_RESET_PIN_N, POWER_DOWN_N};

  // third stage only feeds edge detection, never the first stage
  always_comb
  begin
    meta_nxt = pins;
    sync_nxt = meta_r;
    old_nxt = sync_r;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      meta_r <= '0;
      sync_r <= '0;
      old_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      old_r <= old_nxt;
    end
  end

  // ************************************************************
  // reference activity monitors for automatic selection
  // ************************************************************
  logic [1:0] ref_live;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_act
      logic [`CSSIS_ACT_W-1:0] idle_r;
      logic [`CSSIS_ACT_W-1:0] idle_nxt;
      logic rise;

      assign rise = sync_r[`CSSIS_B_PRI + gi] & ~old_r[`CSSIS_B_PRI + gi];

      // saturating idle count, cleared by every rising edge
      always_comb
      begin
        idle_nxt = idle_r;
        if (rise)
          idle_nxt = '0;
        else if (idle_r != ACT_LIMIT)
          idle_nxt = idle_r + 1'b1;
      end

      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
          idle_r <= ACT_LIMIT; // no edge seen yet, so the source counts as dead
        else
          idle_r <= idle_nxt;
      end

      assign ref_live[gi] = (idle_r != ACT_LIMIT);
    end
  endgenerate

  // ************************************************************
  // input selection
  // ************************************************************
  // automatic choice: primary first, secondary only if primary is dead
  function automatic logic auto_pick(input logic [1:0] live);
    auto_pick = ~live[0] & live[1];
  endfunction

  logic want_sec;
  logic sel_r;
  logic sel_nxt;
  logic mux_r;
  logic mux_nxt;

  always_comb
  begin
    want_sec = 1'b0;
    if (sync_r[`CSSIS_B_MODE])
    begin
      if (PIN_MODE_AUTO)
        want_sec = auto_pick(ref_live);
      else
        want_sec = sync_r[`CSSIS_B_CHOICE];
    end
    else if (!MUX_MANUAL_SELECT_BIT)
      want_sec = auto_pick(ref_live);
    else if (!MUX_REGISTER_CHOICE_BIT)
      want_sec = 1'b0;
    else
      want_sec = sync_r[`CSSIS_B_CHOICE];
  end

  // switch only while old and new sources and the output all sit low,
  // so no runt pulse can appear; a stuck-high source delays the switch
  always_comb
  begin
    sel_nxt = sel_r;
    if (want_sec != sel_r && !mux_r && !sync_r[`CSSIS_B_PRI] && !sync_r[`CSSIS_B_SEC])
      sel_nxt = want_sec;
    mux_nxt = sel_nxt ? sync_r[`CSSIS_B_SEC] : sync_r[`CSSIS_B_PRI];
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sel_r <= 1'b0;
      mux_r <= 1'b0;
    end
    else
    begin
      sel_r <= sel_nxt;
      mux_r <= mux_nxt;
    end
  end

  // ************************************************************
  // reset sources
  // ************************************************************
  logic pin_rst;
  logic in_rst;
  logic pin_rst_r;
  logic pin_rst_nxt;
  logic keep_r;
  logic keep_nxt;
  logic load_r;
  logic load_nxt;

  // either active-low pin holds reset for as long as it stays low
  assign pin_rst = ~sync_r[`CSSIS_B_PDN] | ~sync_r[`CSSIS_B_RSTN];
  // register bit holds reset while 1; the 1-then-0 write releases it
  assign in_rst = pin_rst | REG_RESET_BIT
                | (XTAL_USED & ~sync_r[`CSSIS_B_XTAL]);

  always_comb
  begin
    pin_rst_nxt = pin_rst;
    load_nxt = pin_rst_r & ~pin_rst;
    keep_nxt = keep_r;
    if (pin_rst)
      keep_nxt = 1'b0;
    else if (REG_RESET_BIT)
      keep_nxt = 1'b1;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pin_rst_r <= 1'b1;
      load_r <= 1'b0;
      keep_r <= 1'b0;
    end
    else
    begin
      pin_rst_r <= pin_rst_nxt;
      load_r <= load_nxt;
      keep_r <= keep_nxt;
    end
  end

  // ************************************************************
  // start-up sequencer
  // ************************************************************
  cssis_state_t state_r;
  cssis_state_t state_nxt;
  logic pfd_edge;
  logic fb_edge;
  logic cnt_clr;
  logic cnt_inc;
  logic [`CSSIS_CNT_W-1:0] count;
  logic [`CSSIS_CNT_W-1:0] last;

  assign pfd_edge = mux_nxt & ~mux_r;
  assign fb_edge = sync_r[`CSSIS_B_FB] & ~old_r[`CSSIS_B_FB];

  cssis_cnt #(.WIDTH(`CSSIS_CNT_W)) u_cnt
  (
    .clk(CLK),
    .arst_n(ARST_N),
    .clr(cnt_clr),
    .inc(cnt_inc),
    .count(count)
  );

  // each step ends on the edge that completes its count
  always_comb
  begin
    state_nxt = state_r;
    cnt_clr = 1'b0;
    cnt_inc = 1'b0;
    last = REF_LAST;
    case (state_r)
      ST_RESET:
      begin
        cnt_clr = 1'b1;
        state_nxt = ST_REF_CNT;
      end
      ST_REF_CNT:
      begin
        cnt_inc = pfd_edge;
        last = REF_LAST;
        if (pfd_edge && count == last)
        begin
          cnt_clr = 1'b1;
          state_nxt = ST_FB_CNT;
        end
      end
      ST_FB_CNT:
      begin
        cnt_inc = fb_edge;
        last = FB_CYCLES - 1'b1;
        if (fb_edge && count == last)
        begin
          cnt_clr = 1'b1;
          state_nxt = ST_CAL;
        end
      end
      ST_CAL:
      begin
        cnt_inc = pfd_edge;
        last = CAL_LAST;
        if (pfd_edge && count == last)
        begin
          cnt_clr = 1'b1;
          state_nxt = ST_ON;
        end
      end
      ST_ON:
      begin
        cnt_inc = pfd_edge;
        last = `CSSIS_LOCK_CYCLES - 1'b1;
        if (pfd_edge && count == last)
          state_nxt = ST_LOCKED;
      end
      ST_LOCKED:
        state_nxt = ST_LOCKED;
      default:
        state_nxt = ST_RESET;
    endcase
    if (in_rst)
    begin
      state_nxt = ST_RESET;
      cnt_clr = 1'b1;
      cnt_inc = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end

  // ************************************************************
  // registered outputs, decoded from the next state
  // ************************************************************
  logic on_nxt;
  logic lock_nxt;
  logic out_on_r;
  logic cal_r;
  logic rst_r;
  logic lock_a_r;
  logic lock_b_r;
  logic hold_r;

  assign on_nxt = (state_nxt == ST_ON) || (state_nxt == ST_LOCKED);
  assign lock_nxt = (state_nxt == ST_LOCKED);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      out_on_r <= 1'b0;
      cal_r <= 1'b0;
      rst_r <= 1'b1;
      lock_a_r <= 1'b0;
      lock_b_r <= 1'b0;
      hold_r <= 1'b1;
    end
    else
    begin
      out_on_r <= on_nxt;
      cal_r <= (state_nxt == ST_CAL);
      rst_r <= (state_nxt == ST_RESET);
      lock_a_r <= lock_nxt & LOCK_ON_A;
      lock_b_r <= lock_nxt & LOCK_ON_B;
      hold_r <= ~on_nxt;
    end
  end

  assign MUX_OUTPUT = mux_r;
  assign SELECT_SECONDARY = sel_r;
  assign DEVICE_IN_RESET = rst_r;
  assign LOAD_DEFAULTS = load_r;
  assign CAL_KEEP_PLAN = keep_r;
  assign VCO_CAL_ACTIVE = cal_r;
  assign OUTPUT_ENABLE = out_on_r;
  assign OUTPUT_HOLD_RESET = hold_r;
  assign INDICATOR_PIN_A = lock_a_r;
  assign INDICATOR_PIN_B = lock_b_r;

endmodule

// [cssis_top_sva.sv]
`timescale 1ns/10ps
`include "cssis_cfg.svh"
// ********
// start-up order and input mux checks
// ********
module cssis_chk
#(
  parameter int REF_CYCLES = `CSSIS_REF_CYCLES
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic POWER_DOWN_N,
  input wire logic ACTIVE_LOW_RESET_PIN_N,
  input wire logic REG_RESET_BIT,
  input wire logic PRIMARY_REFERENCE_INPUT,
  input wire logic SECONDARY_REFERENCE_INPUT,
  input wire logic MUX_OUTPUT,
  input wire logic SELECT_SECONDARY,
  input wire logic DEVICE_IN_RESET,
  input wire logic LOAD_DEFAULTS,
  input wire logic CAL_KEEP_PLAN,
  input wire logic VCO_CAL_ACTIVE,
  input wire logic OUTPUT_ENABLE,
  input wire logic OUTPUT_HOLD_RESET,
  input wire logic INDICATOR_PIN_A,
  input wire logic INDICATOR_PIN_B
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  logic rise;
  logic mux_q_r;
  logic [17:0] ref_r;
  logic [17:0] ref_nxt;
  logic [11:0] on_r;
  logic [11:0] on_nxt;
  // pfd edges since reset left and since outputs on; on count saturates
  always_comb
  begin
    rise = MUX_OUTPUT && !mux_q_r;
    ref_nxt = DEVICE_IN_RESET ? 18'h00000 : ref_r + {17'h00000, rise};
    on_nxt = OUTPUT_ENABLE ? on_r + {11'h000, rise && on_r != 12'hFFF} : 12'h000;
  end
  // register the edge counters
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mux_q_r <= 1'b0;
      ref_r <= 18'h00000;
      on_r <= 12'h000;
    end
    else
    begin
      mux_q_r <= MUX_OUTPUT;
      ref_r <= ref_nxt;
      on_r <= on_nxt;
    end
  end
  // pins pass two sync stages before the sequencer sees them
  property p_pin_rst;
    (!POWER_DOWN_N || !ACTIVE_LOW_RESET_PIN_N) [*6] |-> DEVICE_IN_RESET && !VCO_CAL_ACTIVE
      && !OUTPUT_ENABLE && !INDICATOR_PIN_A && !INDICATOR_PIN_B;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset not held");
  property p_reg_rst;
    (REG_RESET_BIT && POWER_DOWN_N && ACTIVE_LOW_RESET_PIN_N) [*6] |->
      DEVICE_IN_RESET && CAL_KEEP_PLAN && !LOAD_DEFAULTS;
  endproperty
  a_reg_rst: assert property (p_reg_rst) else $error("register reset wrong");
  property p_ld_pulse;
    LOAD_DEFAULTS |=> !LOAD_DEFAULTS;
  endproperty
  a_ld_pulse: assert property (p_ld_pulse) else $error("reload not a pulse");
  property p_ld_cause;
    LOAD_DEFAULTS |-> POWER_DOWN_N && ACTIVE_LOW_RESET_PIN_N && !CAL_KEEP_PLAN;
  endproperty
  a_ld_cause: assert property (p_ld_cause) else $error("reload without pin reset");
  property p_cal_hold;
    VCO_CAL_ACTIVE |-> OUTPUT_HOLD_RESET && !OUTPUT_ENABLE;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("outputs live in cal");
  property p_ref_first;
    $rose(VCO_CAL_ACTIVE) |-> ref_r >= REF_CYCLES;
  endproperty
  a_ref_first: assert property (p_ref_first) else $error("cal too early");
  property p_on_after_cal;
    $rose(OUTPUT_ENABLE) |-> $past(VCO_CAL_ACTIVE);
  endproperty
  a_on_after_cal: assert property (p_on_after_cal) else $error("outputs early");
  property p_lock_on;
    (INDICATOR_PIN_A || INDICATOR_PIN_B) |-> OUTPUT_ENABLE && on_r > 12'h7FF;
  endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock too early");
  property p_mux_switch;
    $changed(SELECT_SECONDARY) |-> !MUX_OUTPUT && !$past(MUX_OUTPUT);
  endproperty
  a_mux_switch: assert property (p_mux_switch) else $error("mux switch glitch");
  property p_mux_follow;
    $stable(SELECT_SECONDARY) && $past(ARST_N, 3) |-> MUX_OUTPUT == (SELECT_SECONDARY ?
      $past(SECONDARY_REFERENCE_INPUT, 3) : $past(PRIMARY_REFERENCE_INPUT, 3));
  endproperty
  a_mux_follow: assert property (p_mux_follow) else $error("mux output wrong");
endmodule

bind cssis_top cssis_chk #(.REF_CYCLES(REF_CYCLES)) cssis_chk_inst
(
  .CLK, .ARST_N, .POWER_DOWN_N, .ACTIVE_LOW_RESET_PIN_N, .REG_RESET_BIT,
  .PRIMARY_REFERENCE_INPUT, .SECONDARY_REFERENCE_INPUT, .MUX_OUTPUT, .SELECT_SECONDARY,
  .DEVICE_IN_RESET, .LOAD_DEFAULTS, .CAL_KEEP_PLAN, .VCO_CAL_ACTIVE, .OUTPUT_ENABLE,
  .OUTPUT_HOLD_RESET, .INDICATOR_PIN_A, .INDICATOR_PIN_B
);

// [cssis_ref_model.sv]
`timescale 1ns/10ps
// ********
// host side reference and feedback sources
// ********
module cssis_ref_model
(
  input wire logic clk,
  input wire logic en_pri,
  output logic pri,
  output logic sec,
  fb
);
  logic [2:0] p_r = 3'h0;
  logic [2:0] p_nxt;
  logic [3:0] s_r = 4'h0;
  logic [3:0] s_nxt;
  // periods 8 and 9 cycles, well inside the 20 percent window
  always_comb
  begin
    p_nxt = en_pri ? p_r + 3'h1 : 3'h0;
    s_nxt = (s_r == 4'h8) ? 4'h0 : s_r + 4'h1;
  end
  // phase counters
  always_ff @(posedge clk)
  begin
    p_r <= p_nxt;
    s_r <= s_nxt;
  end
  // stopped primary rests low, restart begins with a low half
  assign pri = p_r[2];
  assign sec = s_r > 4'h4;
  assign fb = s_r[2];
endmodule

// [testbench.sv]
`timescale 1ns/10ps
// ********
// start-up and input mux bench
// ********
module testbench;
  logic clk = 1'b0, arst_n = 1'b0, pdn_n = 1'b1, rst_n = 1'b1, mode = 1'b0, cpin = 1'b0;
  logic xamp = 1'b0, man = 1'b0, rbit = 1'b0, pauto = 1'b0, rreg = 1'b0, xused = 1'b0;
  logic enp = 1'b1;
  logic loa = 1'b1, lob = 1'b0;
  logic mux_q = 1'b0, fb_q = 1'b0, cal_q = 1'b0, oe_q = 1'b0, lk_q = 1'b0;
  int ref_n = 0, fbe_n = 0, cal_n = 0, lk_n = 0;
  // short step counts keep the whole start-up inside the cycle budget
  localparam int REF_CYC = 64, CAL_CYC = 256, FB_CYC = 2048;
  logic pri, sec, fb, mux, ssec, dir, ld, ckp, cal, oe, ohr, ia, ib;
  logic [31:0] seed = 32'h00000024;
  logic [5:0] r;
  logic [5:0] cases [7] = '{6'h20, 6'h00, 6'h2C, 6'h2E, 6'h2A, 6'h29, 6'h31};
  int num_errors = 0, n_tests = 0, ld_n = 0, cyc = 0;
  // 25 MHz
  always #20 clk = ~clk;
  cssis_ref_model cssis_ref_model_inst (.clk(clk), .en_pri(enp), .pri(pri), .sec(sec), .fb(fb));
  cssis_top #(.COUNTER_WIDTH_SETTING(1), .ACT_TIMEOUT(16), .REF_CYCLES(REF_CYC),
    .CAL_CYCLES(CAL_CYC)) cssis_top_inst
  (
    .CLK(clk), .ARST_N(arst_n), .POWER_DOWN_N(pdn_n), .ACTIVE_LOW_RESET_PIN_N(rst_n),
    .INTERFACE_MODE_PIN(mode), .INPUT_CHOICE_PIN(cpin), .XTAL_AMP_OK(xamp),
    .PRIMARY_REFERENCE_INPUT(pri), .SECONDARY_REFERENCE_INPUT(sec), .FEEDBACK_CLOCK(fb),
    .MUX_MANUAL_SELECT_BIT(man), .MUX_REGISTER_CHOICE_BIT(rbit), .PIN_MODE_AUTO(pauto),
    .REG_RESET_BIT(rreg), .XTAL_USED(xused), .LOCK_ON_A(loa), .LOCK_ON_B(lob),
    .MUX_OUTPUT(mux), .SELECT_SECONDARY(ssec), .DEVICE_IN_RESET(dir), .LOAD_DEFAULTS(ld),
    .CAL_KEEP_PLAN(ckp), .VCO_CAL_ACTIVE(cal), .OUTPUT_ENABLE(oe), .OUTPUT_HOLD_RESET(ohr),
    .INDICATOR_PIN_A(ia), .INDICATOR_PIN_B(ib)
  );
  // xorshift source
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // r = {primary on, pin auto, choice pin, register choice, manual, pin mode}
  function automatic logic exp_sel(input logic [5:0] r);
    if (r[0])
      return r[4] ? !r[5] : r[3];
    if (!r[1])
      return !r[5];
    return r[2] & r[3];
  endfunction
  // step n cycles, counting reload pulses on the way
  task automatic run(input int n);
    repeat (n)
    begin
      @(negedge clk);
      ld_n += (ld === 1'b1);
    end
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // detector and feedback rises seen in each start-up step, cleared in reset
  always @(negedge clk)
  begin
    mux_q <= mux;
    fb_q <= fb;
    cal_q <= cal;
    oe_q <= oe;
    lk_q <= ia;
    if (dir)
    begin
      ref_n <= 0;
      fbe_n <= 0;
      cal_n <= 0;
      lk_n <= 0;
    end
    else
    begin
      ref_n <= ref_n + int'(mux && !mux_q && !cal_q && !oe_q);
      fbe_n <= fbe_n + int'(fb && !fb_q && !cal_q && !oe_q);
      cal_n <= cal_n + int'(mux && !mux_q && cal_q);
      lk_n <= lk_n + int'(mux && !mux_q && oe_q && !lk_q);
    end
  end
  // hang guard, the whole run needs about 41600 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    chk("in_reset", 1'b1, dir);
    chk("hold", 1'b1, ohr);
    arst_n = 1'b1;
    run(12);
    chk("reload", 1'b1, ld_n == 1);
    chk("in_reset", 1'b0, dir);
    // register reset, then each pin reset in turn
    for (int p = 0; p < 2; p++)
    begin
      rreg = 1'b1;
      run(6);
      chk("in_reset", 1'b1, dir);
      rreg = 1'b0;
      ld_n = 0;
      run(6);
      chk("in_reset", 1'b0, dir);
      chk("keep_plan", 1'b1, ckp);
      chk("reload", 1'b0, ld_n != 0);
      pdn_n = p[0];
      rst_n = !p[0];
      run(40);
      chk("in_reset", 1'b1, dir);
      chk("keep_plan", 1'b0, ckp);
      pdn_n = 1'b1;
      rst_n = 1'b1;
      ld_n = 0;
      run(8);
      chk("reload", 1'b1, ld_n == 1);
      chk("in_reset", 1'b0, dir);
    end
    // crystal swing gate
    xused = 1'b1;
    run(8);
    chk("in_reset", 1'b1, dir);
    xamp = 1'b1;
    run(8);
    chk("in_reset", 1'b0, dir);
    // corner selections first, then random ones
    for (int i = 0; i < 20; i++)
    begin
      seed = xs(seed);
      r = (i < 7) ? cases[i] : seed[5:0];
      {enp, pauto, cpin, rbit, man, mode} = r;
      run(100);
      chk("select", exp_sel(r), ssec);
    end
    chk("calibrating", 1'b0, cal);
    chk("outputs_on", 1'b0, oe);
    chk("lock", 1'b0, ia | ib);
    // full start-up from a register reset, primary feeding the detector
    {enp, pauto, cpin, rbit, man, mode} = 6'h20;
    rreg = 1'b1;
    run(6);
    rreg = 1'b0;
    while (ia !== 1'b1)
      run(1);
    run(2);
    chk("ref_count", 1'b1, ref_n >= REF_CYC);
    chk("fb_count", 1'b1, fbe_n >= FB_CYC);
    chk("cal_count", 1'b1, cal_n == CAL_CYC);
    chk("outputs_on", 1'b1, oe);
    chk("hold", 1'b0, ohr);
    chk("lock_time", 1'b1, lk_n >= 2048 && lk_n <= 2560);
    chk("lock_b", 1'b0, ib);
    // a register reset drops lock and outputs at once
    rreg = 1'b1;
    run(3);
    chk("lock", 1'b0, ia);
    chk("outputs_on", 1'b0, oe);
    rreg = 1'b0;
    conclude();
  end
endmodule
